// file: logic/epoc_output_ctrl.sv
`timescale 1ns/1ps
module epoc_output_ctrl #(
  parameter int DUTY_BITS = 10
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                pwm_wave,
  input  wire logic                hb_wave_a,
  input  wire logic                hb_wave_b,
  input  wire logic                period_start,
  input  wire logic                compare_match,
  input  wire logic                adc_enabled,
  input  wire logic                capture_pin,
  input  wire logic                cmp1_out,
  input  wire logic                cmp2_out,
  input  wire logic                fault_input_pin_n,
  output epoc_pkg::epoc_pins_t     pwm_pins,
  output logic [DUTY_BITS-1:0]     duty_value,
  output logic [6:0]               deadband_count,
  output logic                     capture_event,
  output logic                     timer_reset,
  output logic                     adc_start,
  output logic                     unit_interrupt_flag,
  output logic                     timer2_period_flag
);
  import epoc_pkg::*;

  if (DUTY_BITS != 10) begin : g_bad_width
    $error("duty value is built from 8 high and 2 low bits");
  end

  epoc_state_t state_reg;
  epoc_state_t state_next;

  // Selected shutdown source, comparators high or fault pin low
  function automatic logic src_active(input logic [2:0] sel, input logic [3:0] syn);
    src_active = (sel[0] & syn[0]) | (sel[1] & syn[1]) | (sel[2] & ~syn[2]);
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == EPOC_OFS_MODE) || (a == EPOC_OFS_SHUT) || (a == EPOC_OFS_STEER) ||
              (a == EPOC_OFS_RESTART) || (a == EPOC_OFS_DUTYHI) || (a == EPOC_OFS_STATUS);
  endfunction

  function automatic logic [31:0] rd_word(input epoc_state_t s, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    unique case (a)
      EPOC_OFS_MODE:    rd_word[7:0] = s.mode_ctl;
      EPOC_OFS_SHUT:    rd_word[7:0] = s.shut_ctl;
      EPOC_OFS_STEER:   rd_word[4:0] = s.steer_ctl;
      EPOC_OFS_RESTART: rd_word[7:0] = s.restart_ctl;
      EPOC_OFS_DUTYHI:  rd_word[7:0] = s.duty_hi;
      EPOC_OFS_STATUS:  rd_word[1:0] = {s.flag_t2, s.flag_unit};
      default:          rd_word = 32'h0000_0000;
    endcase
  endfunction

  // Bus completion and derived conditions
  logic       wr_go;
  logic       src_now;
  logic       pwm_mode;
  logic       pol_ac;
  logic       pol_bd;
  logic       cap_rise;
  logic       cap_fall;
  logic       cap_hit;
  logic [3:0] mode_now;

  assign wr_go    = psel & penable & state_reg.pready & pwrite;
  assign src_now  = src_active(state_reg.shut_ctl[6:4], state_reg.sync_b);
  assign mode_now = state_reg.mode_ctl[3:0];
  assign pwm_mode = (mode_now[3:2] == 2'b11);
  assign pol_ac   = state_reg.mode_ctl[1];
  assign pol_bd   = state_reg.mode_ctl[0];
  assign cap_rise = state_reg.sync_b[3] & ~state_reg.cap_prev;
  assign cap_fall = ~state_reg.sync_b[3] & state_reg.cap_prev;

  // Capture decision; prescaled modes count rising edges
  always_comb
  begin
    cap_hit = 1'b0;
    unique case (mode_now)
      4'h4:    cap_hit = cap_fall;
      4'h5:    cap_hit = cap_rise;
      4'h6:    cap_hit = cap_rise && (state_reg.presc[1:0] == EPOC_PRESC_4[1:0]);
      4'h7:    cap_hit = cap_rise && (state_reg.presc == EPOC_PRESC_16);
      default: cap_hit = 1'b0;
    endcase
  end

  // Next state: bus, shutdown, steering, modes, pins
  always_comb
  begin
    logic sd_force;
    logic pwm_pol_ac;
    logic pwm_pol_bd;
    sd_force   = 1'b0;
    pwm_pol_ac = 1'b0;
    pwm_pol_bd = 1'b0;
    state_next = state_reg;
    state_next.cap_evt   = 1'b0;
    state_next.tmr_rst   = 1'b0;
    state_next.adc_start = 1'b0;

    // Two-cycle APB answer keeps pready straight from a flop
    state_next.pready  = psel & penable & ~state_reg.pready;
    state_next.pslverr = 1'b0;
    if (psel & penable & ~state_reg.pready)
    begin
      state_next.prdata  = rd_word(state_reg, paddr);
      state_next.pslverr = ~addr_ok(paddr);
    end

    // Pins from outside pass two flops before use
    state_next.sync_a   = {capture_pin, fault_input_pin_n, cmp2_out, cmp1_out};
    state_next.sync_b   = state_reg.sync_a;
    state_next.cap_prev = state_reg.sync_b[3];

    // Period boundary commits a pending steering choice
    if (period_start && state_reg.steer_ctl[EPOC_BIT_SYNC])
      state_next.steer_act = state_reg.steer_ctl[3:0];

    // Register writes
    if (wr_go)
    begin
      unique case (paddr)
        EPOC_OFS_MODE:    state_next.mode_ctl = pwdata[7:0];
        EPOC_OFS_RESTART: state_next.restart_ctl = pwdata[7:0];
        EPOC_OFS_DUTYHI:  state_next.duty_hi = pwdata[7:0];
        EPOC_OFS_STEER:
        begin
          state_next.steer_ctl = pwdata[4:0];
          if (!pwdata[EPOC_BIT_SYNC])
            state_next.steer_act = pwdata[3:0];
        end
        EPOC_OFS_SHUT:
        begin
          state_next.shut_ctl[6:0] = pwdata[6:0];
          // Writing a 1 is a software shutdown; clearing is refused while a source persists
          if (pwdata[EPOC_BIT_SDSTAT])
            state_next.shut_ctl[EPOC_BIT_SDSTAT] = 1'b1;
          else if (!src_now)
            state_next.shut_ctl[EPOC_BIT_SDSTAT] = 1'b0;
        end
        EPOC_OFS_STATUS:
        begin
          if (pwdata[0])
            state_next.flag_unit = 1'b0;
          if (pwdata[1])
            state_next.flag_t2 = 1'b0;
        end
        default: state_next.prdata = state_reg.prdata;
      endcase
    end

    // Auto restart drops status once the source is gone; a live source sets it
    if (state_reg.restart_ctl[EPOC_BIT_RSEN] && !src_now)
      state_next.shut_ctl[EPOC_BIT_SDSTAT] = 1'b0;
    if (src_now)
      state_next.shut_ctl[EPOC_BIT_SDSTAT] = 1'b1;

    // Hold output off until the next period after shutdown ends
    if (state_next.shut_ctl[EPOC_BIT_SDSTAT])
      state_next.resume_hold = 1'b1;
    else if (period_start)
      state_next.resume_hold = 1'b0;
    sd_force = state_next.resume_hold;

    // Timer2 flag once the second period of PWM begins
    if (!pwm_mode)
      state_next.pstart_cnt = 2'h0;
    else if (period_start && state_reg.pstart_cnt != 2'h2)
      state_next.pstart_cnt = state_reg.pstart_cnt + 2'h1;
    if (pwm_mode && period_start && state_reg.pstart_cnt == 2'h1)
      state_next.flag_t2 = 1'b1;

    // Compare and capture modes
    state_next.prev_mode = mode_now;
    unique case (mode_now)
      4'h0:
      begin
        state_next.presc   = 4'h0;
        state_next.cmp_pin = 1'b0;
      end
      4'h2: if (compare_match) state_next.cmp_pin = ~state_reg.cmp_pin;
      4'h6, 4'h7: if (cap_rise) state_next.presc = cap_hit ? 4'h0 : state_reg.presc + 4'h1;
      4'h8:
      begin
        if (state_reg.prev_mode != 4'h8)
          state_next.cmp_pin = 1'b0;
        else if (compare_match)
          state_next.cmp_pin = 1'b1;
      end
      4'h9:
      begin
        if (state_reg.prev_mode != 4'h9)
          state_next.cmp_pin = 1'b1;
        else if (compare_match)
          state_next.cmp_pin = 1'b0;
      end
      4'hB:
      begin
        state_next.tmr_rst   = compare_match;
        state_next.adc_start = compare_match & adc_enabled;
      end
      default: state_next.presc = state_reg.presc;
    endcase
    if (cap_hit)
      state_next.cap_evt = 1'b1;
    if (cap_hit || (mode_now[3:2] == 2'b10 && compare_match))
      state_next.flag_unit = 1'b1;

    // Pin routing; reserved codes 0001/0011 leave every pin to the port
    pwm_pol_ac = pwm_wave ^ pol_ac;
    pwm_pol_bd = pwm_wave ^ pol_bd;
    state_next.pins.out   = 4'h0;
    state_next.pins.oe_n  = 4'hF;
    state_next.pins.owned = 4'h0;
    if (pwm_mode)
    begin
      unique case (state_reg.mode_ctl[7:6])
        2'b00:
        begin
          // Single output uses the steering bits; none set means no output
          state_next.pins.owned = state_next.steer_act;
          state_next.pins.out   = {pwm_pol_bd, pwm_pol_ac, pwm_pol_bd, pwm_pol_ac};
        end
        2'b01:
        begin
          state_next.pins.owned = 4'hF;
          state_next.pins.out   = {pwm_pol_bd, pol_ac, pol_bd, ~pol_ac};
        end
        2'b10:
        begin
          // Dead band is already in the two half-bridge inputs
          state_next.pins.owned = 4'h3;
          state_next.pins.out   = {2'b00, hb_wave_b ^ pol_bd, hb_wave_a ^ pol_ac};
        end
        2'b11:
        begin
          state_next.pins.owned = 4'hF;
          state_next.pins.out   = {pol_bd, ~pol_ac, pwm_pol_bd, pol_ac};
        end
      endcase
      state_next.pins.oe_n = ~state_next.pins.owned;
      // Shutdown overrides only the pins that carry the module's output
      if (sd_force)
      begin
        for (int i = 0; i < 4; i++)
        begin
          logic [1:0] pss;
          pss = (i % 2 == 0) ? state_reg.shut_ctl[3:2] : state_reg.shut_ctl[1:0];
          if (state_next.pins.owned[i])
          begin
            state_next.pins.out[i]  = pss[0] & ~pss[1];
            state_next.pins.oe_n[i] = pss[1];
          end
        end
      end
    end
    else if (mode_now == 4'h2 || mode_now == 4'h8 || mode_now == 4'h9)
    begin
      state_next.pins.owned = 4'h1;
      state_next.pins.oe_n  = 4'hE;
      state_next.pins.out   = {3'b000, state_next.cmp_pin};
    end

    // Ten-bit duty value from high byte and two low bits
    state_next.duty_val = {state_reg.duty_hi, state_reg.mode_ctl[5:4]};
  end

  // Single register for all state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg             <= '0;
      state_reg.mode_ctl    <= EPOC_RST_MODE;
      state_reg.shut_ctl    <= EPOC_RST_SHUT;
      state_reg.steer_ctl   <= EPOC_RST_STEER;
      state_reg.steer_act   <= EPOC_RST_STEER[3:0];
      state_reg.restart_ctl <= EPOC_RST_RESTART;
      state_reg.sync_a      <= 4'h4;
      state_reg.sync_b      <= 4'h4;
      state_reg.pins.oe_n   <= 4'hF;
    end
    else
      state_reg <= state_next;
  end

  assign prdata              = state_reg.prdata;
  assign pready              = state_reg.pready;
  assign pslverr             = state_reg.pslverr;
  assign pwm_pins            = state_reg.pins;
  assign duty_value          = state_reg.duty_val;
  assign deadband_count      = state_reg.restart_ctl[6:0];
  assign capture_event       = state_reg.cap_evt;
  assign timer_reset         = state_reg.tmr_rst;
  assign adc_start           = state_reg.adc_start;
  assign unit_interrupt_flag = state_reg.flag_unit;
  assign timer2_period_flag  = state_reg.flag_t2;

  // Checks
  logic wr_steer;
  logic stable_cfg;
  assign wr_steer   = wr_go && (paddr == EPOC_OFS_STEER);
  assign stable_cfg = (state_reg.mode_ctl == state_next.mode_ctl);

  sequence s_sd_end;
    state_reg.shut_ctl[7] ##1 !state_reg.shut_ctl[7];
  endsequence

  sequence s_wait_period;
    !period_start [*1];
  endsequence

  steer_now_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_steer && !pwdata[4] |=> state_reg.steer_act == $past(pwdata[3:0]))
    else $error("unsynced steering not applied");
  steer_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.steer_ctl[4] && !period_start && !wr_steer |=> $stable(state_reg.steer_act))
    else $error("synced steering changed mid period");
  single_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && stable_cfg && state_reg.mode_ctl[7:6] == 2'b00 && !state_next.resume_hold
    && state_next.steer_act[0] |=> pwm_pins.owned[0] && pwm_pins.out[0] == ($past(pwm_wave) ^ $past(pol_ac)))
    else $error("steered pin A wrong polarity");
  fwd_bridge_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && stable_cfg && state_reg.mode_ctl[7:6] == 2'b01 && !state_next.resume_hold
    |=> pwm_pins.out[0] == !$past(pol_ac) && pwm_pins.out[3] == ($past(pwm_wave) ^ $past(pol_bd)))
    else $error("forward bridge pins wrong");
  non_pwm_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pwm_mode && stable_cfg |=> pwm_pins.owned[3:1] == 3'b000)
    else $error("port pins taken outside PWM");
  sd_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    src_now |=> state_reg.shut_ctl[7] && state_reg.resume_hold)
    else $error("shutdown source did not set status");
  sd_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_next.resume_hold && pwm_mode && stable_cfg && state_reg.shut_ctl[3:2] == 2'b00
    && state_next.pins.owned[0] |=> pwm_pins.out[0] == 1'b0 && pwm_pins.oe_n[0] == 1'b0)
    else $error("pin A not driven low in shutdown");
  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg.restart_ctl[7] && state_reg.shut_ctl[7] && !src_now |=> !state_reg.shut_ctl[7])
    else $error("auto restart did not clear status");
  resume_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_wait_period ##0 s_sd_end |-> state_reg.resume_hold)
    else $error("output resumed before period start");
  t2_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwm_mode && period_start && state_reg.pstart_cnt == 2'h1 |=> timer2_period_flag)
    else $error("timer2 flag not set at second period");
  special_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_now == 4'hB && compare_match |=> timer_reset && unit_interrupt_flag)
    else $error("special event missing");
endmodule

// file: shared/epoc_pkg.sv
// What this block does
// - Unsynced steering write takes effect at once
// - Synced steering update waits for period start
// - Steering only in mode 11xx, config 00
// - Mode bit1 sets A/C polarity, bit0 B/D
// - Timer2 flag set as second period begins
// - Config 00 modulates the steered pins (A at reset), others port
// - Forward bridge: D modulated, A active
// - Half bridge: A/B complementary with dead band
// - Reverse bridge: B modulated, C active
// - Non-PWM modes ignore config; A is CCP
// - Duty low bits join high byte, 10 bits
// - Mode 0000 resets unit; 0001/0011 reserved
// - Mode 0010 toggles pin on match
// - Capture modes: fall, rise, 4th, 16th
// - Modes 1000/1001 init pin, flip on match
// - Mode 1010 flags only, pin to I/O
// - Mode 1011 resets timer, starts conversion
// - Shutdown status reads 1 while shut down
// - Source field picks comparators and fault pin
// - A/C shutdown state: 0, 1, tri-state
// - B/D shutdown state: 0, 1, tri-state
// - Active source sets status, forces pins
// - Auto restart clears status when source ends
// - Output resumes only at next period start
// - Steering bit routes polarised PWM to pin
package epoc_pkg;
  localparam logic [7:0] EPOC_OFS_MODE    = 8'h00;
  localparam logic [7:0] EPOC_OFS_SHUT    = 8'h04;
  localparam logic [7:0] EPOC_OFS_STEER   = 8'h08;
  localparam logic [7:0] EPOC_OFS_RESTART = 8'h0C;
  localparam logic [7:0] EPOC_OFS_DUTYHI  = 8'h10;
  localparam logic [7:0] EPOC_OFS_STATUS  = 8'h14;
  localparam logic [7:0] EPOC_RST_MODE    = 8'h00;
  localparam logic [7:0] EPOC_RST_SHUT    = 8'h00;
  localparam logic [4:0] EPOC_RST_STEER   = 5'h01;
  localparam logic [7:0] EPOC_RST_RESTART = 8'h00;
  localparam logic [3:0] EPOC_PRESC_4     = 4'h3;
  localparam logic [3:0] EPOC_PRESC_16    = 4'hF;
  localparam int         EPOC_BIT_SDSTAT  = 7;
  localparam int         EPOC_BIT_RSEN    = 7;
  localparam int         EPOC_BIT_SYNC    = 4;

  // Four pins travel together
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
    logic [3:0] owned;
  } epoc_pins_t;

  typedef struct packed {
    logic [7:0]  mode_ctl;
    logic [7:0]  shut_ctl;
    logic [4:0]  steer_ctl;
    logic [3:0]  steer_act;
    logic [7:0]  restart_ctl;
    logic [7:0]  duty_hi;
    logic        flag_unit;
    logic        flag_t2;
    logic [1:0]  pstart_cnt;
    logic        resume_hold;
    logic [3:0]  sync_a;
    logic [3:0]  sync_b;
    logic        cap_prev;
    logic [3:0]  presc;
    logic        cmp_pin;
    logic [3:0]  prev_mode;
    epoc_pins_t  pins;
    logic [9:0]  duty_val;
    logic        cap_evt;
    logic        tmr_rst;
    logic        adc_start;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } epoc_state_t;
endpackage

// file: test/epoc_bridge_model.sv
`timescale 1ns/1ps
module epoc_bridge_model #(
  parameter int FLT_LAG = 2
) (
  input  wire logic                 pclk,
  input  wire epoc_pkg::epoc_pins_t pins,
  input  wire logic                 trip,
  output logic [3:0]                level,
  output logic                      fault_n
);
  import epoc_pkg::*;
  logic [7:0] lag = 8'h00;

  // Pull-downs hold the switches off on a floating or port-owned pin
  assign level = pins.owned & ~pins.oe_n & pins.out;

  // Driver fault sense answers late, FLT_LAG cycles after a trip
  always @(posedge pclk)
    lag <= {lag[6:0], trip};
  assign fault_n = ~lag[FLT_LAG-1];
endmodule

// file: test/test_enhanced_pwm_output_control.sv
`timescale 1ns/1ps
module test_enhanced_pwm_output_control;
  import epoc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, dh, sd;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, v, hit;
  logic        pwm_wave = 1'b0, hb_wave_a = 1'b0, hb_wave_b = 1'b0, period_start = 1'b0;
  logic        compare_match = 1'b0, adc_enabled = 1'b0, capture_pin = 1'b0;
  logic        cmp1_out = 1'b0, cmp2_out = 1'b0, trip = 1'b0, fault_n;
  logic [9:0]  duty_value;
  logic [6:0]  deadband_count;
  logic        capture_event, timer_reset, adc_start, unit_interrupt_flag, timer2_period_flag;
  epoc_pins_t  pwm_pins;
  logic [3:0]  level, eo, el, tb_cnt = 4'h0, tb_duty = 4'h8, m_s = 4'h0, st_s = 4'h0;
  logic [1:0]  c_s = 2'b00, dl;
  logic        pw = 1'b0, pa = 1'b0, pb = 1'b0, chk_on = 1'b0;
  logic [11:0] got_p;
  int          tests_run = 0, fails = 0, cap_cnt = 0;

  epoc_output_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_wave(pwm_wave), .hb_wave_a(hb_wave_a), .hb_wave_b(hb_wave_b),
    .period_start(period_start), .compare_match(compare_match), .adc_enabled(adc_enabled),
    .capture_pin(capture_pin), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .fault_input_pin_n(fault_n), .pwm_pins(pwm_pins), .duty_value(duty_value),
    .deadband_count(deadband_count), .capture_event(capture_event), .timer_reset(timer_reset),
    .adc_start(adc_start), .unit_interrupt_flag(unit_interrupt_flag),
    .timer2_period_flag(timer2_period_flag));

  epoc_bridge_model #(.FLT_LAG(2)) i_bridge (.pclk(pclk), .pins(pwm_pins), .trip(trip),
    .level(level), .fault_n(fault_n));

  initial forever #20 pclk = ~pclk;

  // Stand-in time base: 16-cycle period, fresh duty each period
  always @(posedge pclk)
  begin
    tb_cnt <= tb_cnt + 4'h1;
    period_start <= (tb_cnt == 4'hF);
    pwm_wave <= (tb_cnt < tb_duty);
    hb_wave_a <= (tb_cnt > 4'h0) && (tb_cnt < tb_duty);
    hb_wave_b <= (tb_cnt > tb_duty);
    if (tb_cnt == 4'hF)
      tb_duty <= 4'($urandom_range(13, 2));
  end

  // Reference pin map: {owned, level} for a PWM mode and configuration
  function automatic logic [7:0] exp_pins(logic [3:0] m, logic [1:0] c, logic [3:0] st,
                                          logic w, logic ha, logic hb);
    logic ac, bd;
    ac = m[1];
    bd = m[0];
    case (c)
      2'b00: return {st, st & {w ^ bd, w ^ ac, w ^ bd, w ^ ac}};
      2'b01: return {4'hF, w ^ bd, ac, bd, ~ac};
      2'b10: return {4'h3, 2'b00, hb ^ bd, ha ^ ac};
      default: return {4'hF, bd, ~ac, w ^ bd, ac};
    endcase
  endfunction

  // Pins lag the waves by one cycle, so compare against last cycle's inputs
  assign got_p = {pwm_pins.owned, pwm_pins.out & pwm_pins.owned, pwm_pins.oe_n & pwm_pins.owned};
  always @(posedge pclk)
  begin
    if (capture_event === 1'b1)
      cap_cnt++;
    if (chk_on)
    begin
      tests_run++;
      if (got_p !== {exp_pins(m_s, c_s, st_s, pw, pa, pb), 4'h0})
      begin
        $display("BAD %0t pins %h mode %h cfg %h", $time, got_p, m_s, c_s);
        fails++;
      end
    end
    pw = pwm_wave;
    pa = hb_wave_a;
    pb = hb_wave_b;
  end

  task automatic end_of_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tmo;
    fails++;
    $display("BAD %0t wait ran out", $time);
    end_of_test();
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      fails++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 20)
        tmo();
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 8'h00);
    cmp(q, exp, what);
  endtask

  task automatic wait_ps;
    int k;
    k = 0;
    @(posedge pclk);
    while (period_start !== 1'b1)
    begin
      k++;
      if (k > 40)
        tmo();
      @(posedge pclk);
    end
  endtask

  task automatic pulse_match;
    @(posedge pclk);
    compare_match <= 1'b1;
    @(posedge pclk);
    compare_match <= 1'b0;
    @(posedge pclk);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h25925081));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(EPOC_OFS_MODE, 32'h00, "mode reset");
    rchk(EPOC_OFS_SHUT, 32'h00, "shutdown reset");
    rchk(EPOC_OFS_RESTART, 32'h00, "restart reset");
    wr(EPOC_OFS_STEER, 8'hE1);
    rchk(EPOC_OFS_STEER, 32'h01, "steering reset, top bits read 0");
    apb(1'b0, 8'h18, 8'h00);
    cmp({31'h0, e}, 32'h1, "unmapped error");
    cmp(q, 32'h0, "unmapped data");
    dh = 8'($urandom);
    wr(EPOC_OFS_DUTYHI, dh);
    // Every PWM polarity code under every output configuration
    for (int c = 0; c < 4; c++)
      for (int m = 12; m < 16; m++)
      begin
        dl = 2'($urandom);
        st_s = 4'($urandom);
        m_s = 4'(m);
        c_s = 2'(c);
        wr(EPOC_OFS_MODE, {c_s, dl, m_s});
        wr(EPOC_OFS_STEER, {4'h0, st_s});
        wait_ps();
        cyc(2);
        chk_on <= 1'b1;
        cyc(20);
        chk_on <= 1'b0;
        // Let the last checked edge pass before the expectation moves
        cyc(1);
        cmp(duty_value, {dh, dl}, "duty");
      end
    // Steering: period-synchronised, then immediate
    wr(EPOC_OFS_MODE, 8'h0C);
    wr(EPOC_OFS_STEER, 8'h01);
    wait_ps();
    wr(EPOC_OFS_STEER, 8'h12);
    cyc(2);
    cmp(pwm_pins.owned, 4'h1, "sync steer early");
    wait_ps();
    cyc(3);
    cmp(pwm_pins.owned, 4'h2, "sync steer late");
    wr(EPOC_OFS_STEER, 8'h04);
    cyc(2);
    cmp(pwm_pins.owned, 4'h4, "immediate steer");
    // Shutdown states per pair, manual restart
    wr(EPOC_OFS_STEER, 8'h0F);
    for (int a = 0; a < 3; a++)
      for (int b = 0; b < 3; b++)
      begin
        sd = {1'b0, 3'b100, 2'(a), 2'(b)};
        eo = {b[1], a[1], b[1], a[1]};
        el = {b == 1, a == 1, b == 1, a == 1};
        wr(EPOC_OFS_SHUT, sd);
        trip <= 1'b1;
        // Fixed wait: a live waveform can match the safe state by chance
        cyc(8);
        cmp({pwm_pins.oe_n, level}, {eo, el}, "shutdown pins");
        rchk(EPOC_OFS_SHUT, {24'h0, 1'b1, sd[6:0]}, "status set");
        trip <= 1'b0;
        cyc(8);
        rchk(EPOC_OFS_SHUT, {24'h0, 1'b1, sd[6:0]}, "status kept");
        wait_ps();
        wr(EPOC_OFS_SHUT, sd);
        cyc(2);
        cmp({pwm_pins.oe_n, level}, {eo, el}, "held to period");
        wait_ps();
        cyc(3);
        cmp(pwm_pins.oe_n, 4'h0, "resumed");
      end
    // Every source code against each source, auto restart on
    sd = 8'($urandom);
    wr(EPOC_OFS_RESTART, {1'b1, sd[6:0]});
    cyc(1);
    cmp(deadband_count, sd[6:0], "dead band");
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 3; k++)
      begin
        hit = (k == 0 && s[0]) || (k == 1 && s[1]) || (k == 2 && s[2]);
        wr(EPOC_OFS_SHUT, {1'b0, 3'(s), 4'h0});
        cmp1_out <= (k == 0);
        cmp2_out <= (k == 1);
        trip <= (k == 2);
        cyc(8);
        rchk(EPOC_OFS_SHUT, {24'h0, hit, 3'(s), 4'h0}, "source");
        {cmp1_out, cmp2_out, trip} <= 3'b000;
        cyc(8);
        rchk(EPOC_OFS_SHUT, {24'h0, 1'b0, 3'(s), 4'h0}, "auto restart");
      end
    wr(EPOC_OFS_SHUT, 8'h00);
    // Compare modes
    for (int m = 8; m < 10; m++)
    begin
      wr(EPOC_OFS_STATUS, 8'h03);
      wr(EPOC_OFS_MODE, 8'(m));
      cyc(2);
      cmp({pwm_pins.owned[0], pwm_pins.out[0], unit_interrupt_flag}, {1'b1, m[0], 1'b0}, "init");
      pulse_match();
      cmp({pwm_pins.out[0], unit_interrupt_flag}, {~m[0], 1'b1}, "on match");
    end
    wr(EPOC_OFS_MODE, 8'h02);
    cyc(2);
    v = pwm_pins.out[0];
    pulse_match();
    cmp(pwm_pins.out[0], {~v}, "toggle 1");
    pulse_match();
    cmp(pwm_pins.out[0], v, "toggle 2");
    wr(EPOC_OFS_STATUS, 8'h03);
    wr(EPOC_OFS_MODE, 8'h0A);
    pulse_match();
    cmp({pwm_pins.owned[0], unit_interrupt_flag}, 2'b01, "soft event");
    wr(EPOC_OFS_STATUS, 8'h03);
    adc_enabled <= 1'b1;
    wr(EPOC_OFS_MODE, 8'h0B);
    pulse_match();
    cmp({timer_reset, adc_start, unit_interrupt_flag}, 3'b111, "special event");
    cyc(1);
    cmp({timer_reset, adc_start}, 2'b00, "event pulses end");
    adc_enabled <= 1'b0;
    pulse_match();
    cmp({timer_reset, adc_start}, 2'b10, "no conversion");
    // Capture modes, prescaler cleared by mode off
    for (int i = 0; i < 4; i++)
    begin
      wr(EPOC_OFS_MODE, 8'h00);
      wr(EPOC_OFS_MODE, 8'(4 + i));
      cap_cnt = 0;
      repeat (i < 2 ? 1 : (i == 2 ? 4 : 16))
      begin
        capture_pin <= 1'b1;
        cyc(4);
        capture_pin <= 1'b0;
        cyc(4);
      end
      cyc(8);
      cmp(cap_cnt, 1, "capture count");
      cmp(pwm_pins.owned, 4'h0, "capture owns no pin");
    end
    // Timer flag after one full period in PWM
    wr(EPOC_OFS_MODE, 8'h00);
    cyc(2);
    cmp(pwm_pins.owned, 4'h0, "mode off");
    wait_ps();
    wr(EPOC_OFS_STATUS, 8'h03);
    wr(EPOC_OFS_MODE, 8'h0C);
    wait_ps();
    cyc(2);
    rchk(EPOC_OFS_STATUS, 32'h0, "no flag after first start");
    wait_ps();
    cyc(2);
    rchk(EPOC_OFS_STATUS, 32'h2, "flag after second start");
    end_of_test();
  end
endmodule
